// ---- pkg/flash_protect_pkg.sv ----
package flash_protect_pkg;
  localparam int ADDR_W = 24;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_SEC_PROT = 8'h36;
  localparam logic [7:0] OP_SEC_UNPROT = 8'h39;
  localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [ADDR_W-1:0] SPAN_PAGE = 24'h0000FF;
  localparam logic [ADDR_W-1:0] SPAN_4K = 24'h000FFF;
  localparam logic [ADDR_W-1:0] SPAN_32K = 24'h007FFF;
  localparam logic [ADDR_W-1:0] SPAN_64K = 24'h00FFFF;
  localparam logic [ADDR_W-1:0] SPAN_CHIP = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] BYTES_OPCODE = 3'h1;
  localparam logic [CNT_W-1:0] BYTES_FULL = 3'h4;
  localparam logic [CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic LATCH_RST = 1'b0;
  localparam logic PROT_RST = 1'b1;
  localparam logic PIN_IDLE = 1'b1;
  localparam int NUM_SECTORS_DFLT = 8;
  localparam int SECTOR_SHIFT_DFLT = 16;
endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_state_t;

  sync_state_t q, d;

  // a change is taken only once the last two stages agree
  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule

// ---- logic/spi_frame_rx.sv ----
`timescale 1ns/1ns
module spi_frame_rx (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic [7:0] opcode,
  output logic [flash_protect_pkg::ADDR_W-1:0] addr,
  output logic [flash_protect_pkg::CNT_W-1:0] byte_count,
  output logic [flash_protect_pkg::CNT_W-1:0] bit_count,
  output logic frame_empty
);
  import flash_protect_pkg::*;

  typedef struct packed {
    logic [7:0] sh;
    logic [CNT_W-1:0] bits;
    logic [CNT_W-1:0] bytes;
    logic [7:0] op;
    logic [ADDR_W-1:0] adr;
  } rx_state_t;

  rx_state_t q, d;
  logic fresh_q;
  logic empty_q;
  logic [CNT_W-1:0] b;
  logic [CNT_W-1:0] n;
  logic [7:0] s;

  // sck stops between frames, so select itself marks the next frame as new
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // fresh_q is set high by this same select rise, so keep its frame value here;
  // relies on the set path being slower than this flop's hold time
  always_ff @(posedge cs_n) begin
    empty_q <= fresh_q;
  end

  always_comb begin
    d = q;
    b = fresh_q ? '0 : q.bits;
    n = fresh_q ? '0 : q.bytes;
    s = {(fresh_q ? 7'h00 : q.sh[6:0]), mosi};
    d.sh = s;
    d.bits = CNT_W'(b + 3'h1);
    d.bytes = n;
    if (b == BIT_LAST) begin
      if (n == '0) begin
        d.op = s;
      end else if (n != BYTES_FULL) begin
        d.adr = {q.adr[ADDR_W-9:0], s};
      end
      if (n != BYTES_FULL) begin
        d.bytes = CNT_W'(n + 3'h1);
      end
    end
  end

  // held after select rises: the core side reads these once sck is idle
  always_ff @(posedge sck) begin
    q <= d;
  end

  assign opcode = q.op;
  assign addr = q.adr;
  assign byte_count = q.bytes;
  assign bit_count = q.bits;
  assign frame_empty = empty_q;
endmodule

// ---- logic/flash_protect.sv ----
`timescale 1ns/1ns
// What this block does
// - program, erase or security writes refused unless write latch set
// - opcode 06h sets the write latch when select rises
// - opcode 04h clears the write latch when select rises
// - bytes after a latch set or clear opcode are ignored
// - short or misaligned latch frames leave the latch unchanged
// - all sector protection bits are one after reset
// - unprotected sectors accept program and erase, protected ones block both
// - opcode 36h plus three address bytes protects the addressed sector
// - opcode 39h plus three address bytes unprotects the addressed sector
// - sector chosen from the address bits just above the sector size, any byte inside it
// - completed sector protect also clears the write latch
// - completed sector unprotect also clears the write latch
// - extra bytes ignored; short or misaligned frame keeps bit, clears latch
// - with the lock bit set, protect is ignored and the latch cleared
// - with the lock bit set, unprotect is ignored and the latch cleared
// - write-protect pin low with lock set hard-locks bits and lock
// - block erase over a protected region does not run
module flash_protect #(
  parameter int NUM_SECTORS = flash_protect_pkg::NUM_SECTORS_DFLT,
  parameter int SECTOR_SHIFT = flash_protect_pkg::SECTOR_SHIFT_DFLT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic protection_regs_lock,
  input wire logic prog_req,
  input wire logic [flash_protect_pkg::ADDR_W-1:0] prog_addr,
  output logic write_enable_latch,
  output logic [NUM_SECTORS-1:0] sector_protect,
  output logic lock_change_allowed,
  output logic erase_start,
  output logic [7:0] erase_opcode,
  output logic [flash_protect_pkg::ADDR_W-1:0] erase_addr,
  output logic erase_deny,
  output logic prog_grant,
  output logic prog_deny
);
  import flash_protect_pkg::*;

  localparam int SEC_W = $clog2(NUM_SECTORS);

  typedef struct packed {
    logic latch;
    logic [NUM_SECTORS-1:0] prot;
    logic csn_prev;
    logic lock_ok;
    logic er_start;
    logic [7:0] er_op;
    logic [ADDR_W-1:0] er_addr;
    logic er_deny;
    logic pg_grant;
    logic pg_deny;
  } core_state_t;

  core_state_t q, d;

  logic [7:0] fr_opcode;
  logic [ADDR_W-1:0] fr_addr;
  logic [CNT_W-1:0] fr_bytes;
  logic [CNT_W-1:0] fr_bits;
  logic fr_empty;
  logic [1:0] pins_lvl;
  logic csn_lvl;
  logic wp_lvl;
  logic frame_end;
  logic fr_ok;
  logic op_done;
  logic addr_done;
  logic [SEC_W-1:0] fr_sec;

  spi_frame_rx u_rx (
    .sck(sck),
    .cs_n(cs_n),
    .mosi(mosi),
    .opcode(fr_opcode),
    .addr(fr_addr),
    .byte_count(fr_bytes),
    .bit_count(fr_bits),
    .frame_empty(fr_empty)
  );

  pin_sync #(.W(2), .RST_VAL({PIN_IDLE, PIN_IDLE})) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin({wp_n, cs_n}),
    .level(pins_lvl)
  );

  assign csn_lvl = pins_lvl[0];
  assign wp_lvl = pins_lvl[1];

  // index bits above the sector size; wraps for addresses past the array
  function automatic logic [SEC_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    sector_of = a[SECTOR_SHIFT +: SEC_W];
  endfunction

  function automatic logic [ADDR_W-1:0] erase_span(input logic [7:0] op);
    case (op)
      OP_ERASE_PAGE: erase_span = SPAN_PAGE;
      OP_ERASE_4K: erase_span = SPAN_4K;
      OP_ERASE_32K: erase_span = SPAN_32K;
      OP_ERASE_64K: erase_span = SPAN_64K;
      default: erase_span = SPAN_CHIP;
    endcase
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    is_erase = (op == OP_ERASE_PAGE) || (op == OP_ERASE_4K) ||
               (op == OP_ERASE_32K) || (op == OP_ERASE_64K) ||
               (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
  endfunction

  function automatic logic is_chip(input logic [7:0] op);
    is_chip = (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
  endfunction

  // any protected sector touched by the erased span blocks the erase
  function automatic logic erase_blocked(input logic [7:0] op,
                                         input logic [ADDR_W-1:0] a,
                                         input logic [NUM_SECTORS-1:0] p);
    logic [ADDR_W-1:0] span;
    logic [SEC_W-1:0] lo;
    logic [SEC_W-1:0] hi;
    logic hit;
    span = erase_span(op);
    lo = sector_of(a & ~span);
    hi = sector_of(a | span);
    hit = 1'b0;
    for (int i = 0; i < NUM_SECTORS; i++) begin
      if (p[i] && (SEC_W'(i) >= lo) && (SEC_W'(i) <= hi)) begin
        hit = 1'b1;
      end
    end
    erase_blocked = hit;
  endfunction

  // frame counters are read only here, after select has settled high
  assign frame_end = csn_lvl & ~q.csn_prev;
  assign fr_ok = frame_end & ~fr_empty;
  assign op_done = (fr_bits == '0) && (fr_bytes >= BYTES_OPCODE);
  assign addr_done = (fr_bits == '0) && (fr_bytes == BYTES_FULL);
  assign fr_sec = sector_of(fr_addr);

  always_comb begin
    d = q;
    d.csn_prev = csn_lvl;
    d.lock_ok = ~(protection_regs_lock & ~wp_lvl);
    d.er_start = 1'b0;
    d.er_deny = 1'b0;
    d.pg_grant = 1'b0;
    d.pg_deny = 1'b0;
    if (fr_ok) begin
      case (fr_opcode)
        OP_LATCH_SET: begin
          if (op_done) begin
            d.latch = 1'b1;
          end
        end
        OP_LATCH_CLR: begin
          if (op_done) begin
            d.latch = 1'b0;
          end
        end
        OP_SEC_PROT, OP_SEC_UNPROT: begin
          // lock alone blocks; with wp low that is also the hard lock
          if (q.latch && addr_done && !protection_regs_lock) begin
            d.prot[fr_sec] = (fr_opcode == OP_SEC_PROT);
          end
          d.latch = 1'b0;
        end
        default: begin
          if (is_erase(fr_opcode)) begin
            if (!q.latch) begin
              d.er_deny = 1'b1;
            end else if ((is_chip(fr_opcode) ? !op_done : !addr_done) ||
                         erase_blocked(fr_opcode, fr_addr, q.prot)) begin
              d.er_deny = 1'b1;
              d.latch = 1'b0;
            end else begin
              d.er_start = 1'b1;
              d.er_op = fr_opcode;
              d.er_addr = fr_addr;
              d.latch = 1'b0;
            end
          end
        end
      endcase
    end
    if (prog_req) begin
      if (q.latch && !q.prot[sector_of(prog_addr)]) begin
        d.pg_grant = 1'b1;
      end else begin
        d.pg_deny = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
      q.latch <= LATCH_RST;
      q.prot <= {NUM_SECTORS{PROT_RST}};
      q.csn_prev <= PIN_IDLE;
      q.lock_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign write_enable_latch = q.latch;
  assign sector_protect = q.prot;
  assign lock_change_allowed = q.lock_ok;
  assign erase_start = q.er_start;
  assign erase_opcode = q.er_op;
  assign erase_addr = q.er_addr;
  assign erase_deny = q.er_deny;
  assign prog_grant = q.pg_grant;
  assign prog_deny = q.pg_deny;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  latch_set_a: assert property (
    fr_ok && fr_opcode == OP_LATCH_SET && op_done |=> write_enable_latch)
    else $error("latch set frame did not set the latch");

  latch_clear_a: assert property (
    fr_ok && fr_opcode == OP_LATCH_CLR && op_done |=> !write_enable_latch)
    else $error("latch clear frame did not clear the latch");

  short_latch_a: assert property (
    fr_ok && (fr_opcode == OP_LATCH_SET || fr_opcode == OP_LATCH_CLR) && !op_done
    |=> $stable(write_enable_latch))
    else $error("aborted latch frame changed the latch");

  reset_prot_a: assert property (
    $fell(rst) |-> (&sector_protect) && !write_enable_latch)
    else $error("sectors not protected after reset");

  protect_done_a: assert property (
    fr_ok && fr_opcode == OP_SEC_PROT && write_enable_latch && addr_done &&
    !protection_regs_lock
    |=> sector_protect[$past(fr_sec)] && !write_enable_latch)
    else $error("sector protect did not take effect");

  unprotect_done_a: assert property (
    fr_ok && fr_opcode == OP_SEC_UNPROT && write_enable_latch && addr_done &&
    !protection_regs_lock
    |=> !sector_protect[$past(fr_sec)] && !write_enable_latch)
    else $error("sector unprotect did not take effect");

  partial_addr_a: assert property (
    fr_ok && (fr_opcode == OP_SEC_PROT || fr_opcode == OP_SEC_UNPROT) && !addr_done
    |=> $stable(sector_protect) && !write_enable_latch)
    else $error("short protect frame changed a sector or kept the latch");

  locked_ignore_a: assert property (
    protection_regs_lock |=> $stable(sector_protect))
    else $error("protection bits changed while locked");

  prog_check_a: assert property (
    prog_req && (!write_enable_latch || sector_protect[sector_of(prog_addr)])
    |=> prog_deny && !prog_grant)
    else $error("program granted without latch or on protected sector");

  erase_guard_a: assert property (
    erase_start |-> $past(write_enable_latch) && !write_enable_latch &&
    !erase_blocked(erase_opcode, erase_addr, $past(sector_protect)))
    else $error("erase started without latch or over protected sector");

  erase_no_latch_a: assert property (
    fr_ok && is_erase(fr_opcode) && !write_enable_latch
    |=> erase_deny && !erase_start && !write_enable_latch)
    else $error("erase without latch was not denied");

  prot_needs_latch_a: assert property (
    fr_ok && (fr_opcode == OP_SEC_PROT || fr_opcode == OP_SEC_UNPROT) && !write_enable_latch
    |=> $stable(sector_protect) && !write_enable_latch)
    else $error("protection changed without the latch");

  locked_latch_a: assert property (
    fr_ok && (fr_opcode == OP_SEC_PROT || fr_opcode == OP_SEC_UNPROT) && protection_regs_lock
    |=> !write_enable_latch)
    else $error("locked protect frame kept the latch");

  hard_lock_a: assert property (
    protection_regs_lock && !wp_lvl |=> !lock_change_allowed)
    else $error("hard lock not reported");

  latch_seen_c: cover property (fr_ok && fr_opcode == OP_LATCH_SET && op_done);
  unprot_seen_c: cover property (fr_ok && fr_opcode == OP_SEC_UNPROT && addr_done);
  erase_seen_c: cover property (erase_start);
  deny_seen_c: cover property (erase_deny);
  locked_seen_c: cover property (fr_ok && fr_opcode == OP_SEC_PROT && protection_regs_lock);
endmodule

// ---- verif/spi_host_model.sv ----
`timescale 1ns/1ns
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    // an empty frame during reset gives the receiver a real select rise to start from
    cs_n = 1'b0;
    #5 cs_n = 1'b1;
  end
  // mode 0: sck rests low and only toggles inside a frame; gap slows the host down
  task automatic send(input logic [39:0] f, input int n, input int gap);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = f[39-i];
      #(15 + gap) sck = 1'b1;
      #(15 + gap) sck = 1'b0;
    end
    #15 cs_n = 1'b1;
    // released line has no pull, so never leave the last bit sitting there
    mosi = ~mosi;
  endtask
endmodule

// ---- verif/tb_flash_protect.sv ----
`timescale 1ns/1ns
module tb_flash_protect;
  import flash_protect_pkg::*;
  localparam int NS = 8;
  localparam int SH = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sck, cs_n, mosi;
  logic wp_n = 1'b1;
  logic lock = 1'b0;
  logic prog_req = 1'b0;
  logic [ADDR_W-1:0] prog_addr = '0;
  logic latch, lca, e_start, e_deny, p_grant, p_deny;
  logic [NS-1:0] prot;
  logic [7:0] e_op;
  logic [ADDR_W-1:0] a, e_addr;
  logic exp_latch = 1'b0;
  logic exp_lca = 1'b1;
  logic [NS-1:0] exp_prot = '1;
  logic chk = 1'b0;
  logic [NS+1:0] sq[$];
  logic pq[$];
  logic [32:0] eq[$];
  logic [32:0] en;
  int mismatches = 0;
  int cmp_count = 0;
  localparam logic [7:0] ERASE_OPS [6] = '{OP_ERASE_PAGE, OP_ERASE_4K, OP_ERASE_32K,
    OP_ERASE_64K, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};

  always #50 core_clk = ~core_clk;

  spi_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi));

  flash_protect #(.NUM_SECTORS(NS), .SECTOR_SHIFT(SH)) DUT (
    .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
    .protection_regs_lock(lock), .prog_req(prog_req), .prog_addr(prog_addr),
    .write_enable_latch(latch), .sector_protect(prot), .lock_change_allowed(lca),
    .erase_start(e_start), .erase_opcode(e_op), .erase_addr(e_addr), .erase_deny(e_deny),
    .prog_grant(p_grant), .prog_deny(p_deny));

  task automatic note_err(input string msg);
    mismatches++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic cmp_state(input logic [NS+1:0] e);
    cmp_count++;
    if ({lca, latch, prot} !== e) begin
      note_err("latch, lock gate or protection bits differ");
    end
  endtask

  task automatic cmp_val(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] e,
                         input string msg);
    cmp_count++;
    if (got !== e) begin
      note_err(msg);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (!rst) begin
      if (chk) begin
        cmp_state(sq.pop_front());
      end
      if (p_grant || p_deny) begin
        if (pq.size() == 0) begin
          note_err("unexpected program answer");
        end else begin
          cmp_val(ADDR_W'(p_grant), ADDR_W'(pq.pop_front()), "program answer wrong");
        end
      end
      if (e_start || e_deny) begin
        if (eq.size() == 0) begin
          note_err("unexpected erase answer");
        end else begin
          en = eq.pop_front();
          cmp_val(ADDR_W'(e_start), ADDR_W'(en[32]), "erase answer wrong");
          if (en[32]) begin
            cmp_val(ADDR_W'(e_op), ADDR_W'(en[31:24]), "erase opcode wrong");
            cmp_val(e_addr, en[23:0], "erase address wrong");
          end
        end
      end
    end
  end

  task automatic note();
    sq.push_back({exp_lca, exp_latch, exp_prot});
    chk = 1'b1;
    @(posedge core_clk);
    #1 chk = 1'b0;
  endtask

  // fixed wait: the answer lands on the 5th core edge after select rises
  task automatic frame(input logic [39:0] f, input int n, input int gap);
    host.send(f, n, gap);
    repeat (8) @(posedge core_clk);
    #1;
    note();
  endtask

  task automatic drain();
    for (int i = 0; i < 4 && pq.size() + eq.size() != 0; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (pq.size() + eq.size() != 0) begin
      note_err("answer missing");
      complete_run();
    end
  endtask

  task automatic wren();
    exp_latch = 1'b1;
    frame({OP_LATCH_SET, 32'h0}, 8, 0);
  endtask

  task automatic prog(input logic [ADDR_W-1:0] ad, input logic e);
    prog_addr = ad;
    prog_req = 1'b1;
    pq.push_back(e);
    @(posedge core_clk);
    #1 prog_req = 1'b0;
    drain();
  endtask

  task automatic erase(input logic [7:0] op, input logic [ADDR_W-1:0] ad, input logic e);
    eq.push_back({e, op, ad});
    exp_latch = 1'b0;
    frame({op, ad, 8'h00}, (op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B) ? 8 : 32, 0);
    drain();
  endtask

  function automatic logic [ADDR_W-1:0] addr_of(input int s);
    return (ADDR_W'(s) << SH) | ADDR_W'($urandom() & 32'hFFFF);
  endfunction

  initial begin
    void'($urandom(1));
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    note();
    frame({OP_LATCH_SET, 32'h0}, 7, 0);
    exp_latch = 1'b1;
    frame({OP_LATCH_SET, 8'hA5, 24'h0}, 16, 20);
    frame({OP_LATCH_CLR, 32'h0}, 12, 0);
    prog(addr_of(2), 1'b0);
    exp_latch = 1'b0;
    frame({OP_LATCH_CLR, 8'hFF, 24'h0}, 16, 0);
    for (int s = 0; s < NS; s++) begin
      a = addr_of(s);
      frame({OP_SEC_UNPROT, a, 8'h00}, 32, 0);
      wren();
      exp_prot[s] = 1'b0;
      exp_latch = 1'b0;
      frame({OP_SEC_UNPROT, a, 8'h00}, 32, 0);
      prog(a, 1'b0);
      wren();
      prog(a, 1'b1);
      prog(addr_of((s + 1) % NS), !exp_prot[(s + 1) % NS]);
      exp_latch = 1'b0;
      frame({OP_LATCH_CLR, 32'h0}, 8, 0);
    end
    wren();
    exp_latch = 1'b0;
    frame({OP_SEC_PROT, 24'h030000, 8'h00}, 24, 0);
    wren();
    exp_latch = 1'b0;
    frame({OP_SEC_PROT, 8'h45, 24'h0}, 36, 0);
    wren();
    exp_prot[3] = 1'b1;
    exp_latch = 1'b0;
    frame({OP_SEC_PROT, addr_of(3), 8'h5A}, 40, 0);
    foreach (ERASE_OPS[i]) begin
      wren();
      erase(ERASE_OPS[i], addr_of(5), i < 4);
    end
    wren();
    erase(OP_ERASE_64K, addr_of(3), 1'b0);
    erase(OP_ERASE_4K, addr_of(6), 1'b0);
    lock = 1'b1;
    wren();
    exp_latch = 1'b0;
    frame({OP_SEC_UNPROT, addr_of(3), 8'h00}, 32, 0);
    wren();
    exp_latch = 1'b0;
    frame({OP_SEC_PROT, addr_of(5), 8'h00}, 32, 0);
    wp_n = 1'b0;
    exp_lca = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    note();
    wp_n = 1'b1;
    exp_lca = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    note();
    drain();
    complete_run();
  end
endmodule
